// ---- verilog/rmpc_map.svh ----
// Constant map for the reset mode and pin configuration block.
`ifndef RMPC_MAP_SVH
`define RMPC_MAP_SVH
`define RMPC_EXT_ACCESS_CYCLES 2'h3
`define RMPC_RESET_ROMSEL      1'b1
`define RMPC_RESET_EMUSEL      1'b1
`define RMPC_PORT_A_DATA       4'h0
`define RMPC_PORT_B_DATA       4'h1
`define RMPC_PORT_AB_DDR       4'h2
`define RMPC_PORT_C_DATA       4'h3
`define RMPC_PORT_E_DATA       4'h4
`define RMPC_PORT_E_DDR        4'h5
`define RMPC_PORT_E_PAR        4'h6
`define RMPC_PORT_F_DATA       4'h7
`define RMPC_PORT_F_DDR        4'h8
`define RMPC_PORT_F_PAR        4'h9
`define RMPC_PORT_GH_DATA      4'ha
`define RMPC_PORT_GH_DDR       4'hb
`endif

// ---- verilog/rmpc_pkg.sv ----
// Types shared by the reset mode and pin configuration block.
package rmpc_pkg;
  typedef enum logic [1:0] {
    RMPC_MODE_EXP16  = 2'b00,
    RMPC_MODE_EXP8   = 2'b01,
    RMPC_MODE_SINGLE = 2'b10
  } rmpc_mode_t;

  typedef struct packed {
    logic mode_error_strap;
    logic bus_width_strap;
    logic port_e_strap;
    logic port_f_strap;
    logic emulator_strap;
    logic rom_emulation_strap;
    logic clock_source_strap;
  } rmpc_straps_t;

  typedef struct packed {
    logic port_a_b_sel;
    logic port_c_sel;
    logic port_e_sel;
    logic port_f_sel;
    logic port_g_sel;
    logic port_h_sel;
    logic data_hi_bus;
    logic data_lo_bus;
    logic addr_bus;
    logic grant_sel;
    logic chip_sel_fixed;
    logic emulator_en;
    logic rom_emul_en;
    logic synth_en;
  } rmpc_config_t;
endpackage

// ---- verilog/rmpc_top.sv ----
// Reset-time mode selection, pin function assignment and emulator select logic.
`timescale 1ns/1ps
`default_nettype none
`include "rmpc_map.svh"

// Functional notes
// - Error strap high, width strap high: 8-bit expanded, low data byte is port.
// - 8-bit expanded mode always disables emulator operation.
// - In 8-bit mode low port_e/port_f straps select ports E and F.
// - In 8-bit mode chip select, function code and grant pins are fixed.
// - Error strap low: single-chip mode, ports A, B, G and H on buses.
// - Single-chip has no external data bus and always selects all ports.
// - Single-chip makes port C and E/F bits; chip select and grants fixed.
// - Emulator mode when emulator and width straps low, error strap high.
// - Emulator mode maps port A,B,E,G,H registers and port E assignment externally.
// - Port C data and port F registers stay internal in emulator mode.
// - Emulator select asserts from address strobe fall on external register access.
// - Block does not answer externally mapped accesses; outside logic does.
// - Each externally mapped access lasts three system clock cycles.
// - ROM emulation enabled when width, emulator, ROM straps low, error high.
// - With ROM emulation, ROM select stays high even on valid masked ROM accesses.
// - In emulation ROM gives no acknowledge; an external bus cycle runs.
// - Flash lacks emulator support, so ROM select stays high permanently.
// - Clock strap high at reset selects the synthesized system clock.
// - Clock strap low disables synthesizer; external clock input must drive.
// - Clock rate changes never disturb stored register or memory content.
// - Data strap pins pulled up: unstrapped reads high, default function.
// - Error strap high, width strap low: 16-bit expanded with full data bus.
module rmpc_top (
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  input  wire rmpc_pkg::rmpc_straps_t STRAPS,
  input  wire logic                  ACCESS_START,
  input  wire logic [3:0]            ACCESS_REG,
  input  wire logic                  ROM_ACCESS,
  output logic                       PORT_ACCESS_INT,
  output logic                       EXT_BUS_CYCLE,
  output logic                       EMULATOR_SELECT_OUTPUT_N,
  output logic                       ROM_EMULATION_SELECT_N,
  output logic [1:0]                 MODE,
  output rmpc_pkg::rmpc_config_t     PIN_CONFIG
);
  import rmpc_pkg::*;

  // ****************************************
  // Strap capture
  // ****************************************
  // Straps are sampled on every reset cycle, so the value held is the one at
  // the last edge before reset releases. The pull-ups live in the pad ring; an open
  // data strap therefore arrives here as one.
  rmpc_straps_t straps_r;
  logic         in_reset_r;
  rmpc_mode_t   mode_nxt;
  rmpc_config_t cfg_nxt;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      straps_r <= STRAPS;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= 1'b0;
    end
  end

  // ****************************************
  // Mode and pin decode
  // ****************************************
  always_comb begin
    cfg_nxt = '0;
    if (!straps_r.mode_error_strap) begin
      mode_nxt = RMPC_MODE_SINGLE;
    end else if (straps_r.bus_width_strap) begin
      mode_nxt = RMPC_MODE_EXP8;
    end else begin
      mode_nxt = RMPC_MODE_EXP16;
    end
    cfg_nxt.chip_sel_fixed = 1'b1;
    cfg_nxt.synth_en = straps_r.clock_source_strap;
    unique case (mode_nxt)
      RMPC_MODE_SINGLE: begin
        // Expanded strap options are ignored here.
        cfg_nxt.port_a_b_sel = 1'b1;
        cfg_nxt.port_c_sel   = 1'b1;
        cfg_nxt.port_e_sel   = 1'b1;
        cfg_nxt.port_f_sel   = 1'b1;
        cfg_nxt.port_g_sel   = 1'b1;
        cfg_nxt.port_h_sel   = 1'b1;
        cfg_nxt.grant_sel    = 1'b1;
      end
      RMPC_MODE_EXP8: begin
        cfg_nxt.addr_bus    = 1'b1;
        cfg_nxt.data_hi_bus = 1'b1;
        cfg_nxt.port_h_sel  = 1'b1;
        cfg_nxt.port_e_sel  = ~straps_r.port_e_strap;
        cfg_nxt.port_f_sel  = ~straps_r.port_f_strap;
        cfg_nxt.grant_sel   = 1'b1;
        cfg_nxt.emulator_en = 1'b0;
      end
      RMPC_MODE_EXP16: begin
        cfg_nxt.addr_bus    = 1'b1;
        cfg_nxt.data_hi_bus = 1'b1;
        cfg_nxt.data_lo_bus = 1'b1;
        cfg_nxt.port_e_sel  = ~straps_r.port_e_strap;
        cfg_nxt.port_f_sel  = ~straps_r.port_f_strap;
        cfg_nxt.grant_sel   = straps_r.emulator_strap;
        cfg_nxt.emulator_en = ~straps_r.emulator_strap;
        cfg_nxt.rom_emul_en = ~straps_r.emulator_strap
                            & ~straps_r.rom_emulation_strap;
      end
      default: begin
        cfg_nxt.chip_sel_fixed = 1'b1;
      end
    endcase
  end

  // The configuration is loaded once, on the first cycle after reset, and is
  // never touched again; a clock rate change only slows these edges.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      MODE       <= RMPC_MODE_SINGLE;
      PIN_CONFIG <= '0;
    end else if (in_reset_r) begin
      MODE       <= mode_nxt;
      PIN_CONFIG <= cfg_nxt;
    end
  end

  // ****************************************
  // Emulator register decode
  // ****************************************
  logic       ext_mapped;
  logic [1:0] ext_cnt_r;

  always_comb begin
    unique case (ACCESS_REG)
      `RMPC_PORT_A_DATA, `RMPC_PORT_B_DATA, `RMPC_PORT_AB_DDR,
      `RMPC_PORT_E_DATA, `RMPC_PORT_E_DDR, `RMPC_PORT_E_PAR,
      `RMPC_PORT_GH_DATA, `RMPC_PORT_GH_DDR: ext_mapped = PIN_CONFIG.emulator_en;
      default: ext_mapped = 1'b0;
    endcase
  end

  // ACCESS_START marks the address strobe falling edge of a register access.
  // The select holds for three clocks, the full length of the access.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ext_cnt_r                <= 2'h0;
      EMULATOR_SELECT_OUTPUT_N <= `RMPC_RESET_EMUSEL;
    end else if (ACCESS_START && ext_mapped && ext_cnt_r == 2'h0) begin
      ext_cnt_r                <= `RMPC_EXT_ACCESS_CYCLES - 2'h1;
      EMULATOR_SELECT_OUTPUT_N <= 1'b0;
    end else if (ext_cnt_r != 2'h0) begin
      ext_cnt_r <= ext_cnt_r - 2'h1;
    end else begin
      EMULATOR_SELECT_OUTPUT_N <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PORT_ACCESS_INT <= 1'b0;
    end else begin
      PORT_ACCESS_INT <= ACCESS_START && !ext_mapped;
    end
  end

  // ****************************************
  // ROM emulation
  // ****************************************
  // The flash arrays cannot be emulated, so the select never asserts even when
  // enabled; only the external cycle for the unacknowledged access remains.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ROM_EMULATION_SELECT_N <= `RMPC_RESET_ROMSEL;
      EXT_BUS_CYCLE          <= 1'b0;
    end else begin
      ROM_EMULATION_SELECT_N <= 1'b1;
      EXT_BUS_CYCLE          <= ROM_ACCESS && PIN_CONFIG.rom_emul_en;
    end
  end

  // ****************************************
  // Assertion helpers
  // ****************************************
  // A new select starts only from an idle counter; a start before the last cycle
  // of a running select is ignored, so the checks below key on this term alone.
  logic       ext_start;
  logic [2:0] sel_low_cnt_r;

  assign ext_start = ACCESS_START && ext_mapped && ext_cnt_r == 2'h0;

  // Length of the current select pulse. Counting here keeps the bound on the
  // pulse out of long repetitions in the properties.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sel_low_cnt_r <= 3'h0;
    end else if (ext_start) begin
      sel_low_cnt_r <= 3'h1;
    end else if (!EMULATOR_SELECT_OUTPUT_N && sel_low_cnt_r != 3'h7) begin
      sel_low_cnt_r <= sel_low_cnt_r + 3'h1;
    end else if (EMULATOR_SELECT_OUTPUT_N) begin
      sel_low_cnt_r <= 3'h0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_ext_start;
    ACCESS_START && ext_mapped && ext_cnt_r == 2'h0;
  endsequence

  // The select stands low for the whole access, then lifts unless a fresh
  // access to a mapped register followed at once.
  sequence s_sel_held;
    !EMULATOR_SELECT_OUTPUT_N [*3];
  endsequence

  sequence s_sel_release;
    EMULATOR_SELECT_OUTPUT_N || $past(ext_start);
  endsequence

  a_emusel_three_cycles: assert property (@(posedge MCLK) disable iff (RESET)
    s_ext_start |=> s_sel_held ##1 s_sel_release)
    else $error("emulator select not three cycles");
  a_emusel_idle: assert property (@(posedge MCLK) disable iff (RESET)
    !PIN_CONFIG.emulator_en && ext_cnt_r == 2'h0 |=> EMULATOR_SELECT_OUTPUT_N)
    else $error("emulator select asserted while disabled");
  a_exp8_no_emu: assert property (@(posedge MCLK) disable iff (RESET)
    MODE == RMPC_MODE_EXP8 |-> !PIN_CONFIG.emulator_en)
    else $error("emulator enabled in 8-bit mode");
  a_single_ports: assert property (@(posedge MCLK) disable iff (RESET)
    MODE == RMPC_MODE_SINGLE && !$past(RESET) |-> PIN_CONFIG.port_g_sel
      && PIN_CONFIG.port_e_sel && !PIN_CONFIG.data_hi_bus)
    else $error("single-chip ports not selected");
  a_config_stable: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r && !$past(in_reset_r) |-> $stable(PIN_CONFIG) && $stable(MODE))
    else $error("configuration changed after reset");
  a_no_internal_ans: assert property (@(posedge MCLK) disable iff (RESET)
    s_ext_start |=> !PORT_ACCESS_INT)
    else $error("internal answer to external register");
  a_romsel_high: assert property (@(posedge MCLK) disable iff (RESET)
    ROM_ACCESS ##1 1'b1 |-> ROM_EMULATION_SELECT_N)
    else $error("rom select driven low");
  a_rom_ext_cycle: assert property (@(posedge MCLK) disable iff (RESET)
    ROM_ACCESS && PIN_CONFIG.rom_emul_en |=> EXT_BUS_CYCLE)
    else $error("no external cycle for emulated rom");
  a_exp8_mode: assert property (@(posedge MCLK) disable iff (RESET)
    in_reset_r && straps_r.mode_error_strap && straps_r.bus_width_strap
      |=> MODE == RMPC_MODE_EXP8)
    else $error("8-bit mode not entered");

  // ****************************************
  // Assertions on the reset decode
  // ****************************************
  // Once in_reset_r has dropped, the configuration has been loaded from the
  // captured straps; the checks below, bar a_reset_values, a_straps_held and a_exp8_no_rom, only look from that point on.
  a_reset_values: assert property (@(posedge MCLK)
    RESET |=> MODE == RMPC_MODE_SINGLE && PIN_CONFIG == '0 && EMULATOR_SELECT_OUTPUT_N
      && ROM_EMULATION_SELECT_N && !PORT_ACCESS_INT && !EXT_BUS_CYCLE)
    else $error("outputs not at reset values");
  a_straps_held: assert property (@(posedge MCLK) disable iff (RESET)
    !RESET |=> $stable(straps_r))
    else $error("captured straps moved outside reset");
  a_single_select: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r && !straps_r.mode_error_strap |-> MODE == RMPC_MODE_SINGLE
      && PIN_CONFIG.port_a_b_sel && PIN_CONFIG.port_g_sel && PIN_CONFIG.port_h_sel)
    else $error("single-chip mode not entered");
  a_single_no_bus: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r && MODE == RMPC_MODE_SINGLE |-> !PIN_CONFIG.data_lo_bus
      && !PIN_CONFIG.addr_bus && !PIN_CONFIG.emulator_en && !PIN_CONFIG.rom_emul_en)
    else $error("external bus left on in single-chip mode");
  a_single_pins: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r && MODE == RMPC_MODE_SINGLE |-> PIN_CONFIG.port_c_sel
      && PIN_CONFIG.port_f_sel && PIN_CONFIG.grant_sel && PIN_CONFIG.chip_sel_fixed)
    else $error("single-chip pin functions wrong");
  a_exp8_buses: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r && MODE == RMPC_MODE_EXP8 |-> PIN_CONFIG.addr_bus && PIN_CONFIG.data_hi_bus
      && !PIN_CONFIG.data_lo_bus && PIN_CONFIG.port_h_sel)
    else $error("8-bit bus split wrong");
  a_exp8_ports: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r && MODE == RMPC_MODE_EXP8 |-> PIN_CONFIG.port_e_sel == !straps_r.port_e_strap
      && PIN_CONFIG.port_f_sel == !straps_r.port_f_strap)
    else $error("8-bit port straps not applied");
  a_exp8_fixed: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r && MODE == RMPC_MODE_EXP8 |-> PIN_CONFIG.grant_sel
      && PIN_CONFIG.chip_sel_fixed && !PIN_CONFIG.port_c_sel)
    else $error("8-bit fixed pin functions wrong");
  a_exp8_no_rom: assert property (@(posedge MCLK) disable iff (RESET)
    MODE == RMPC_MODE_EXP8 |-> !PIN_CONFIG.rom_emul_en)
    else $error("rom emulation enabled in 8-bit mode");
  a_exp16_buses: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r && straps_r.mode_error_strap && !straps_r.bus_width_strap
      |-> MODE == RMPC_MODE_EXP16 && PIN_CONFIG.addr_bus && PIN_CONFIG.data_hi_bus
      && PIN_CONFIG.data_lo_bus)
    else $error("16-bit mode not entered");
  a_emu_enable: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r |-> PIN_CONFIG.emulator_en == (straps_r.mode_error_strap
      && !straps_r.bus_width_strap && !straps_r.emulator_strap))
    else $error("emulator enable does not follow straps");
  a_rom_emu_enable: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r |-> PIN_CONFIG.rom_emul_en == (straps_r.mode_error_strap
      && !straps_r.bus_width_strap && !straps_r.emulator_strap
      && !straps_r.rom_emulation_strap))
    else $error("rom emulation enable does not follow straps");
  a_clock_source: assert property (@(posedge MCLK) disable iff (RESET)
    !in_reset_r |-> PIN_CONFIG.synth_en == straps_r.clock_source_strap)
    else $error("clock source does not follow strap");

  // ****************************************
  // Assertions on register and ROM accesses
  // ****************************************
  a_emusel_bounded: assert property (@(posedge MCLK) disable iff (RESET)
    !EMULATOR_SELECT_OUTPUT_N |-> sel_low_cnt_r != 3'h0
      && sel_low_cnt_r <= {1'b0, `RMPC_EXT_ACCESS_CYCLES})
    else $error("emulator select low too long or without access");
  a_emusel_cause: assert property (@(posedge MCLK) disable iff (RESET)
    $fell(EMULATOR_SELECT_OUTPUT_N) |-> $past(ACCESS_START && ext_mapped))
    else $error("emulator select fell without mapped access");
  a_ext_regs_mapped: assert property (@(posedge MCLK) disable iff (RESET)
    ACCESS_START && PIN_CONFIG.emulator_en && ACCESS_REG inside {`RMPC_PORT_A_DATA,
      `RMPC_PORT_B_DATA, `RMPC_PORT_AB_DDR, `RMPC_PORT_E_DATA, `RMPC_PORT_E_DDR,
      `RMPC_PORT_E_PAR, `RMPC_PORT_GH_DATA, `RMPC_PORT_GH_DDR} |=> !PORT_ACCESS_INT)
    else $error("mapped register answered internally");
  a_int_regs_kept: assert property (@(posedge MCLK) disable iff (RESET)
    ACCESS_START && ACCESS_REG inside {`RMPC_PORT_C_DATA, `RMPC_PORT_F_DATA,
      `RMPC_PORT_F_DDR, `RMPC_PORT_F_PAR} |=> PORT_ACCESS_INT)
    else $error("internal register not answered");
  a_int_pulse: assert property (@(posedge MCLK) disable iff (RESET)
    ACCESS_START && !ext_mapped |=> PORT_ACCESS_INT)
    else $error("internal access without answer");
  a_int_one_cycle: assert property (@(posedge MCLK) disable iff (RESET)
    !ACCESS_START |=> !PORT_ACCESS_INT)
    else $error("internal answer without access");
  a_rom_sel_enabled: assert property (@(posedge MCLK) disable iff (RESET)
    PIN_CONFIG.rom_emul_en |-> ROM_EMULATION_SELECT_N)
    else $error("rom select low while emulation enabled");
  a_rom_no_cycle: assert property (@(posedge MCLK) disable iff (RESET)
    !PIN_CONFIG.rom_emul_en |=> !EXT_BUS_CYCLE)
    else $error("external cycle without rom emulation");
  a_rom_cycle_pulse: assert property (@(posedge MCLK) disable iff (RESET)
    !ROM_ACCESS |=> !EXT_BUS_CYCLE)
    else $error("external cycle without rom access");
endmodule
`default_nettype wire

// ---- dv/rmpc_board.sv ----
// Board strap levels and port replacement unit facing the mode block.
`timescale 1ns/1ps
`default_nettype none
module rmpc_board (
  input  wire logic              clk,
  input  wire logic [6:0]        want,
  input  wire logic              sel_n,
  output rmpc_pkg::rmpc_straps_t straps,
  output logic                   pru_ack
);
  import rmpc_pkg::*;
  logic [1:0] cnt_r;
  // Straps arrive resolved; a board may tie the error strap low for good.
  assign straps = rmpc_straps_t'(want);
  // The replacement unit answers in the block's place in the cycle after the third select cycle.
  always_ff @(posedge clk) begin
    cnt_r   <= sel_n ? 2'h0 : cnt_r + 2'h1;
    pru_ack <= !sel_n && cnt_r == 2'h2;
  end
endmodule
`default_nettype wire

// ---- dv/test_reset_mode_pin_configuration.sv ----
// Self-checking testbench for the reset mode and pin configuration block.
`timescale 1ns/1ps
`default_nettype none
module test_reset_mode_pin_configuration;
  import rmpc_pkg::*;
  logic         mclk, reset, start, rom, pint, ext, sel_n, rom_n, ack;
  logic [3:0]   areg;
  logic [6:0]   want;
  logic [1:0]   mode;
  rmpc_straps_t straps;
  rmpc_config_t cfg;
  int           n_mismatch, checks, cycles;

  rmpc_board board (.clk(mclk), .want(want), .sel_n(sel_n), .straps(straps), .pru_ack(ack));
  rmpc_top DUT (.MCLK(mclk), .RESET(reset), .STRAPS(straps), .ACCESS_START(start),
    .ACCESS_REG(areg), .ROM_ACCESS(rom), .PORT_ACCESS_INT(pint), .EXT_BUS_CYCLE(ext),
    .EMULATOR_SELECT_OUTPUT_N(sel_n), .ROM_EMULATION_SELECT_N(rom_n), .MODE(mode),
    .PIN_CONFIG(cfg));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Ceiling is nearly twenty times the length of the whole sequence.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reset_to(logic [6:0] s);
    @(negedge mclk);
    want  = s;
    reset = 1'b1;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  // ******************************************************
  // Access sequences
  // ******************************************************
  task automatic access(logic [3:0] r, logic mapped);
    @(negedge mclk);
    start = 1'b1;
    areg  = r;
    for (int k = 1; k <= 4; k++) begin
      @(negedge mclk);
      start = 1'b0;
      chk("emu_select_n", sel_n, !(mapped && k < 4));
      chk("port_int", pint, k == 1 && !mapped);
      if (k == 4) chk("pru_ack", ack, mapped);
    end
  endtask

  task automatic rom_pair(logic en);
    @(negedge mclk);
    rom = 1'b1;
    @(negedge mclk);
    chk("ext_cycle", ext, en);
    @(negedge mclk);
    rom = 1'b0;
    chk("ext_cycle", ext, en);
    chk("rom_select_n", rom_n, 1'b1);
    @(negedge mclk);
    chk("ext_cycle", ext, 1'b0);
  endtask

  task automatic t_single();
    for (int i = 0; i < 2; i++) begin
      reset_to(i == 0 ? 7'h3f : 7'h00);
      chk("mode", mode, 2'h2);
      chk("ports", {cfg.port_a_b_sel, cfg.port_c_sel, cfg.port_e_sel, cfg.port_f_sel,
        cfg.port_g_sel, cfg.port_h_sel}, 6'h3f);
      chk("buses", {cfg.data_hi_bus, cfg.data_lo_bus, cfg.addr_bus, cfg.emulator_en}, 4'h0);
      chk("synth", cfg.synth_en, i == 0);
      access(4'h0, 1'b0);
    end
    $display("single chip test done");
  endtask

  task automatic t_exp8();
    for (int e = 0; e < 4; e++) begin
      reset_to({2'b11, e[1:0], 3'b001});
      chk("mode", mode, 2'h1);
      chk("port_e", cfg.port_e_sel, !e[1]);
      chk("port_f", cfg.port_f_sel, !e[0]);
      chk("buses", {cfg.data_hi_bus, cfg.data_lo_bus, cfg.addr_bus, cfg.port_h_sel}, 4'hb);
      chk("emu", {cfg.emulator_en, cfg.rom_emul_en, cfg.grant_sel,
        cfg.chip_sel_fixed}, 4'h3);
    end
    access(4'h4, 1'b0);
    rom_pair(1'b0);
    $display("eight bit test done");
  endtask

  task automatic t_exp16();
    reset_to(7'h5f);
    chk("mode", mode, 2'h0);
    chk("cfg", {cfg.data_hi_bus, cfg.data_lo_bus, cfg.addr_bus, cfg.emulator_en,
      cfg.synth_en}, 5'h1d);
    access(4'h0, 1'b0);
    reset_to(7'h58);
    chk("emu", {cfg.emulator_en, cfg.rom_emul_en, cfg.synth_en,
      cfg.grant_sel}, 4'hc);
    for (int r = 0; r < 12; r++) access(r[3:0], 1'(12'hc77 >> r));
    rom_pair(1'b1);
    want = 7'h3f;
    repeat (3) @(negedge mclk);
    chk("held", {mode, cfg.emulator_en}, 3'h1);
    $display("sixteen bit test done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {reset, start, rom, areg, want} = {1'b1, 1'b0, 1'b0, 4'h0, 7'h3f};
    t_single();
    t_exp8();
    t_exp16();
    results();
  end
endmodule
`default_nettype wire
